// *** include/vtpg_pkg.sv ***
// Package: register map, field positions, reset values and timing constants
package vtpg_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CTL    = 8'h64;  // pattern_control
  localparam logic [7:0]  IDX_CFG    = 8'h65;  // pattern_config
  localparam logic [7:0]  IDX_FTIME  = 8'h6C;  // scroll_frame_time
  localparam logic [7:0]  IDX_HTIM   = 8'h70;  // Horizontal total/active
  localparam logic [7:0]  IDX_VTIM   = 8'h71;  // Vertical total/active
  localparam logic [7:0]  IDX_PORCH  = 8'h72;  // Sync widths and porches
  localparam logic [7:0]  IDX_STAT   = 8'h73;  // Generator status

  // Reset values
  localparam logic [7:0]  CTL_RST    = 8'h10;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [7:0]  FTIME_RST  = 8'h01;
  localparam logic [31:0] HTIM_RST   = 32'h0320_0280;
  localparam logic [31:0] VTIM_RST   = 32'h020D_01E0;
  localparam logic [31:0] PORCH_RST  = 32'h2102_3060;

  // pattern_control fields
  localparam int CTL_EN      = 0;
  localparam int CTL_VREV    = 1;
  localparam int CTL_BARS    = 2;
  localparam int CTL_SEL_LO  = 4;

  // pattern_config fields
  localparam int CFG_ASCRL   = 0;
  localparam int CFG_INV     = 1;
  localparam int CFG_TSEL    = 2;
  localparam int CFG_EXTCLK  = 3;
  localparam int CFG_18B     = 4;
  localparam logic [7:0] CFG_WMASK = 8'h1F;

  // Pattern codes
  localparam logic [3:0] PAT_FIRST = 4'h1;
  localparam logic [3:0] PAT_LAST  = 4'hD;
  localparam logic [3:0] PAT_VCOM  = 4'hF;

  // Internal divided pixel clock: one pixel step every DIV_CYC cycles
  localparam logic [7:0] DIV_CYC   = 8'h02;

  // Pixel FIFO shape: {vs, hs, de, r, g, b}
  localparam int FIFO_W = 27;
  localparam int FIFO_D = 8;

  // Synchronised pin bit positions
  localparam int PIN_CLK = 0;
  localparam int PIN_DE  = 1;
  localparam int PIN_HS  = 2;
  localparam int PIN_VS  = 3;

endpackage : vtpg_pkg

// *** rtl/vtpg_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides
module vtpg_fifo #(
  parameter int W = 27,
  parameter int D = 8
) (
  input  wire logic         clk,      // Clock
  input  wire logic         rst_n,    // Async reset, active low
  input  wire logic         in_valid, // Write request
  output logic              in_ready, // Not full
  input  wire logic [W-1:0] in_data,  // Write data
  output logic              out_valid,// Not empty
  input  wire logic         out_ready,// Read accept
  output logic      [W-1:0] out_data  // Head word
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [AW:0]   cnt_ff, nxt_cnt;
  logic          push, pop;

  ////////////////////////////////////////////////////////////////////////////
  // Pointer and count update
  always_comb
  begin
    push    = in_valid && in_ready;
    pop     = out_valid && out_ready;
    nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
    nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
    nxt_cnt = cnt_ff;
    if (push && !pop)
      nxt_cnt = (AW+1)'(cnt_ff + 1'b1);
    else if (pop && !push)
      nxt_cnt = (AW+1)'(cnt_ff - 1'b1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage array, written only on accepted pushes
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ff] <= in_data;
  end

  // Honest flags from the word count
  assign in_ready  = (cnt_ff != (AW+1)'(D));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ff];

endmodule : vtpg_fifo

// *** rtl/vtpg_top.sv ***
// Video test-pattern generator with APB registers and pixel FIFO
// Function
// - VCOM band order follows band-reverse bit
// - Patterns generated only while enable bit set
// - Depth select set gives 18-bit, six MSBs
// - Depth select clear gives 24-bit, 256 levels
// - Internal timing: clock-source bit picks pixel clock
// - External timing: clock-source bit has no effect
// - Timing select high uses programmed frame timing
// - Timing select low follows external sync pins
// - Invert bit inverts every generated colour
// - Auto-scroll advances after programmed frame count
// - Without auto-scroll current pattern stays
// - Fixed select ignored while auto-scroll enabled
//
// Chosen here: the APB interface to the registers.
module vtpg_top
  import vtpg_pkg::*;
(
  input  wire logic        pclk,      // System clock
  input  wire logic        presetn,   // Async reset, active low
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB enable
  input  wire logic        pwrite,    // APB direction
  input  wire logic [11:0] paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic             pready,    // APB ready
  output logic      [31:0] prdata,    // APB read data
  output logic             pslverr,   // APB error, unmapped address
  input  wire logic        ext_pclk,  // External pixel clock pin
  input  wire logic        ext_de,    // External data enable pin
  input  wire logic        ext_hs,    // External horizontal sync pin
  input  wire logic        ext_vs,    // External vertical sync pin
  output logic             vid_valid, // Pixel word available
  input  wire logic        vid_ready, // Downstream accepts pixel
  output logic      [23:0] vid_rgb,   // Pixel colour R,G,B
  output logic             vid_de,    // Pixel data enable
  output logic             vid_hs,    // Pixel horizontal sync
  output logic             vid_vs     // Pixel vertical sync
);

  ////////////////////////////////////////////////////////////////////////////
  // Register bank and APB slave
  logic [7:0]  ctl_ff, nxt_ctl, cfg_ff, nxt_cfg, ftime_ff, nxt_ftime;
  logic [31:0] htim_ff, nxt_htim, vtim_ff, nxt_vtim;
  logic [31:0] porch_ff, nxt_porch, prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic        ovf_ff, nxt_ovf;
  logic [7:0]  fcnt_ff, nxt_fcnt;
  logic [3:0]  pat_ff, nxt_pat;
  logic [7:0]  idx;
  logic        wr_acc, mapped;
  logic        ovf_set;

  // Decode, read mux and write strobes
  always_comb
  begin
    idx         = paddr[9:2];
    mapped      = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
                  (idx == IDX_CTL || idx == IDX_CFG || idx == IDX_FTIME ||
                   idx == IDX_HTIM || idx == IDX_VTIM ||
                   idx == IDX_PORCH || idx == IDX_STAT);
    wr_acc      = psel && penable && pready_ff && pwrite && mapped;
    nxt_pready  = psel && !penable;
    nxt_pslverr = psel && !penable && !mapped;
    nxt_prdata  = prdata_ff;
    if (psel && !penable)
    begin
      // Refused accesses read zero through the default branch
      unique case (mapped ? idx : 8'h00)
        IDX_CTL:   nxt_prdata = {24'h000000, ctl_ff};
        IDX_CFG:   nxt_prdata = {24'h000000, cfg_ff};
        IDX_FTIME: nxt_prdata = {24'h000000, ftime_ff};
        IDX_HTIM:  nxt_prdata = htim_ff;
        IDX_VTIM:  nxt_prdata = vtim_ff;
        IDX_PORCH: nxt_prdata = porch_ff;
        IDX_STAT:  nxt_prdata = {19'h00000, ovf_ff, pat_ff, fcnt_ff};
        default:   nxt_prdata = 32'h00000000;
      endcase
    end
    nxt_ctl   = (wr_acc && idx == IDX_CTL)   ? pwdata[7:0] : ctl_ff;
    nxt_cfg   = (wr_acc && idx == IDX_CFG)   ? (pwdata[7:0] & CFG_WMASK)
                                             : cfg_ff;
    nxt_ftime = (wr_acc && idx == IDX_FTIME) ? pwdata[7:0] : ftime_ff;
    nxt_htim  = (wr_acc && idx == IDX_HTIM)  ? pwdata : htim_ff;
    nxt_vtim  = (wr_acc && idx == IDX_VTIM)  ? pwdata : vtim_ff;
    nxt_porch = (wr_acc && idx == IDX_PORCH) ? pwdata : porch_ff;
    // Overflow flag: a new overflow wins over a status write clear
    nxt_ovf   = ovf_set ? 1'b1 :
                ((wr_acc && idx == IDX_STAT && pwdata[12]) ? 1'b0 : ovf_ff);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_ff     <= CTL_RST;
      cfg_ff     <= CFG_RST;
      ftime_ff   <= FTIME_RST;
      htim_ff    <= HTIM_RST;
      vtim_ff    <= VTIM_RST;
      porch_ff   <= PORCH_RST;
      prdata_ff  <= 32'h00000000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      ovf_ff     <= 1'b0;
    end
    else
    begin
      ctl_ff     <= nxt_ctl;
      cfg_ff     <= nxt_cfg;
      ftime_ff   <= nxt_ftime;
      htim_ff    <= nxt_htim;
      vtim_ff    <= nxt_vtim;
      porch_ff   <= nxt_porch;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      ovf_ff     <= nxt_ovf;
    end
  end

  assign pready  = pready_ff;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: two flops, third flop only for edge detect
  logic [3:0] s1_ff, s2_ff, s3_ff;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_ff <= 4'h0;
      s2_ff <= 4'h0;
      s3_ff <= 4'h0;
    end
    else
    begin
      s1_ff <= {ext_vs, ext_hs, ext_de, ext_pclk};
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel step selection and frame timing
  logic [7:0]  div_ff, nxt_div;
  logic [15:0] hcnt_ff, nxt_hcnt, vcnt_ff, nxt_vcnt;
  logic [15:0] x_ff, nxt_x, y_ff, nxt_y;
  logic [15:0] hstart, vstart;
  logic        en, tsel, ext_edge, div_pulse, step, push;
  logic        de_c, hs_c, vs_c, frame_end, fifo_in_ready;

  always_comb
  begin
    en        = ctl_ff[CTL_EN];
    tsel      = cfg_ff[CFG_TSEL];
    ext_edge  = s2_ff[PIN_CLK] && !s3_ff[PIN_CLK];
    div_pulse = (div_ff == DIV_CYC - 8'h01);
    nxt_div   = (!en || div_pulse) ? 8'h00 : 8'(div_ff + 8'h01);
    hstart    = 16'(porch_ff[7:0]) + 16'(porch_ff[15:8]);
    vstart    = 16'(porch_ff[23:16]) + 16'(porch_ff[31:24]);
    // Clock source matters only under internal timing
    if (tsel)
      step = en && fifo_in_ready &&
             (cfg_ff[CFG_EXTCLK] ? ext_edge : div_pulse);
    else
      step = en && ext_edge;
    nxt_hcnt  = hcnt_ff;
    nxt_vcnt  = vcnt_ff;
    nxt_x     = x_ff;
    nxt_y     = y_ff;
    frame_end = 1'b0;
    if (tsel)
    begin
      // Own timing from programmed sizes, widths and porches
      hs_c = (hcnt_ff < 16'(porch_ff[7:0]));
      vs_c = (vcnt_ff < 16'(porch_ff[23:16]));
      de_c = (hcnt_ff >= hstart) &&
             (hcnt_ff < 16'(hstart + htim_ff[15:0])) &&
             (vcnt_ff >= vstart) &&
             (vcnt_ff < 16'(vstart + vtim_ff[15:0]));
      if (step)
      begin
        if (de_c)
          nxt_x = 16'(x_ff + 16'h0001);
        if (hcnt_ff == 16'(htim_ff[31:16] - 16'h0001))
        begin
          nxt_hcnt = 16'h0000;
          nxt_x    = 16'h0000;
          if (x_ff != 16'h0000 || de_c)
            nxt_y = 16'(y_ff + 16'h0001);
          if (vcnt_ff == 16'(vtim_ff[31:16] - 16'h0001))
          begin
            nxt_vcnt  = 16'h0000;
            nxt_y     = 16'h0000;
            frame_end = 1'b1;
          end
          else
            nxt_vcnt = 16'(vcnt_ff + 16'h0001);
        end
        else
          nxt_hcnt = 16'(hcnt_ff + 16'h0001);
      end
    end
    else
    begin
      // Follow external sync, counting positions from data enable
      de_c = s2_ff[PIN_DE];
      hs_c = s2_ff[PIN_HS];
      vs_c = s2_ff[PIN_VS];
      if (step)
      begin
        nxt_hcnt = {15'h0000, de_c};
        if (de_c)
          nxt_x = 16'(x_ff + 16'h0001);
        else if (hcnt_ff[0])
        begin
          nxt_x = 16'h0000;
          nxt_y = 16'(y_ff + 16'h0001);
        end
        nxt_vcnt = {15'h0000, vs_c};
        if (vs_c && !vcnt_ff[0])
        begin
          nxt_y     = 16'h0000;
          frame_end = 1'b1;
        end
      end
    end
    if (!en)
    begin
      nxt_hcnt = 16'h0000;
      nxt_vcnt = 16'h0000;
      nxt_x    = 16'h0000;
      nxt_y    = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff  <= 8'h00;
      hcnt_ff <= 16'h0000;
      vcnt_ff <= 16'h0000;
      x_ff    <= 16'h0000;
      y_ff    <= 16'h0000;
    end
    else
    begin
      div_ff  <= nxt_div;
      hcnt_ff <= nxt_hcnt;
      vcnt_ff <= nxt_vcnt;
      x_ff    <= nxt_x;
      y_ff    <= nxt_y;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Auto-scroll frame counter and pattern pointer
  always_comb
  begin
    nxt_fcnt = fcnt_ff;
    nxt_pat  = pat_ff;
    if (!en || !cfg_ff[CFG_ASCRL])
      nxt_fcnt = 8'h00;
    else if (frame_end)
    begin
      if (8'(fcnt_ff + 8'h01) >= ftime_ff)
      begin
        nxt_fcnt = 8'h00;
        nxt_pat  = (pat_ff >= PAT_LAST || pat_ff < PAT_FIRST) ?
                   PAT_FIRST : 4'(pat_ff + 4'h1);
      end
      else
        nxt_fcnt = 8'(fcnt_ff + 8'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fcnt_ff <= 8'h00;
      pat_ff  <= PAT_FIRST;
    end
    else
    begin
      fcnt_ff <= nxt_fcnt;
      pat_ff  <= nxt_pat;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Colour generation
  logic [3:0]  sel;
  logic [7:0]  lvl_h, lvl_v, r, g, b;
  logic [2:0]  bar;
  logic [1:0]  band;
  logic [15:0] q1, q2, q3;
  logic [23:0] rgb;

  always_comb
  begin
    // Fixed select ignored under auto-scroll
    sel   = cfg_ff[CFG_ASCRL] ? pat_ff : ctl_ff[7:CTL_SEL_LO];
    // 18-bit depth keeps six MSBs, 64 levels
    lvl_h = cfg_ff[CFG_18B] ? {x_ff[7:2], 2'b00} : x_ff[7:0];
    lvl_v = cfg_ff[CFG_18B] ? {y_ff[7:2], 2'b00} : y_ff[7:0];
    bar   = 3'(({16'h0000, x_ff} << 3) / {16'h0000, (htim_ff[15:0] | 16'h1)});
    q1    = htim_ff[15:0] >> 2;
    q2    = htim_ff[15:0] >> 1;
    q3    = 16'(q1 + q2);
    band  = (x_ff >= q3) ? 2'd3 : (x_ff >= q2) ? 2'd2 :
            (x_ff >= q1) ? 2'd1 : 2'd0;
    {r, g, b} = 24'h000000;
    if (ctl_ff[CTL_BARS])
    begin
      // White, yellow, cyan, green, magenta, red, blue, black
      r = (bar == 3'd0 || bar == 3'd1 || bar == 3'd4 || bar == 3'd5) ?
          8'hFF : 8'h00;
      g = (bar <= 3'd3) ? 8'hFF : 8'h00;
      b = (bar == 3'd0 || bar == 3'd2 || bar == 3'd4 || bar == 3'd6) ?
          8'hFF : 8'h00;
    end
    else
    begin
      unique case (sel)
        4'h1:    {r, g, b} = 24'hFFFFFF;
        4'h2:    {r, g, b} = 24'h000000;
        4'h3:    {r, g, b} = 24'hFF0000;
        4'h4:    {r, g, b} = 24'h00FF00;
        4'h5:    {r, g, b} = 24'h0000FF;
        4'h6:    {r, g, b} = {lvl_h, lvl_h, lvl_h};
        4'h7:    r = lvl_h;
        4'h8:    g = lvl_h;
        4'h9:    b = lvl_h;
        4'hA:    {r, g, b} = {lvl_v, lvl_v, lvl_v};
        4'hB:    r = lvl_v;
        4'hC:    g = lvl_v;
        4'hD:    b = lvl_v;
        PAT_VCOM:
        begin
          // Bands yellow,cyan,blue,red or blue,cyan,yellow,red
          if (band == 2'd3)
            r = 8'hFF;
          else if (band == 2'd1)
            {g, b} = 16'hFFFF;
          else if ((band == 2'd0) != ctl_ff[CTL_VREV])
            {r, g} = 16'hFFFF;
          else
            b = 8'hFF;
        end
        default: {r, g, b} = 24'h808080;
      endcase
    end
    rgb = {r, g, b};
    if (cfg_ff[CFG_INV])
      rgb = ~rgb;
    if (cfg_ff[CFG_18B])
      rgb = rgb & 24'hFCFCFC;
    push    = step;
    ovf_set = step && !fifo_in_ready;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel FIFO towards the output path
  logic [FIFO_W-1:0] fifo_out;

  vtpg_fifo #(
    .W (FIFO_W),
    .D (FIFO_D)
  ) u_fifo (
    .clk       (pclk),
    .rst_n     (presetn),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({vs_c, hs_c, de_c, (de_c ? rgb : 24'h000000)}),
    .out_valid (vid_valid),
    .out_ready (vid_ready),
    .out_data  (fifo_out)
  );

  assign {vid_vs, vid_hs, vid_de, vid_rgb} = fifo_out;

endmodule : vtpg_top

// *** bench/vtpg_sink.sv ***
// Downstream video consumer model with stall and rate control
module vtpg_sink
(
  input  wire logic        pclk,      // Clock
  input  wire logic        presetn,   // Reset, active low
  input  wire logic        stall,     // Hold off all pops
  input  wire logic        fast,      // Pop every cycle when set
  input  wire logic        arm,       // Restart capture
  input  wire logic        vid_valid, // Pixel available
  output logic             vid_ready, // Pop request
  input  wire logic [23:0] vid_rgb,   // Pixel colour
  input  wire logic        vid_de,    // Pixel data enable
  output logic      [1:0]  n_cap,     // Active pixels captured
  output logic      [23:0] cap0,      // First active pixel
  output logic      [23:0] cap1       // Second active pixel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic slow_ff;
  // Pops promptly or every other cycle; keeps first two active words
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      slow_ff   <= 1'b0;
      vid_ready <= 1'b0;
      n_cap     <= 2'd0;
    end
    else
    begin
      slow_ff   <= !slow_ff;
      vid_ready <= !stall && (fast || slow_ff);
      if (arm)
        n_cap <= 2'd0;
      else if (vid_valid && vid_ready && vid_de && n_cap != 2'd2)
      begin
        if (n_cap == 2'd0)
          cap0 <= vid_rgb;
        else
          cap1 <= vid_rgb;
        n_cap <= n_cap + 2'd1;
      end
    end
  end
endmodule : vtpg_sink

// *** bench/vtpg_assertions.sv ***
// Port checker for the pattern generator, bound to its top
module vtpg_chk
  import vtpg_pkg::*;
(
  input wire logic        pclk,      // Clock
  input wire logic        presetn,   // Reset
  input wire logic        psel,      // Select
  input wire logic        penable,   // Enable
  input wire logic        pwrite,    // Direction
  input wire logic [11:0] paddr,     // Address
  input wire logic [31:0] pwdata,    // Write data
  input wire logic        pready,    // Ready
  input wire logic [31:0] prdata,    // Read data
  input wire logic        pslverr,   // Error
  input wire logic        vid_valid, // Pixel valid
  input wire logic        vid_ready, // Pixel pop
  input wire logic [23:0] vid_rgb,   // Colour
  input wire logic        vid_de     // Data enable
);
  timeunit 1ns;
  timeprecision 1ps;
  logic en_ff, nxt_en, d18_ff, nxt_d18, acc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  // Shadow of the enable and depth bits
  assign acc = psel && penable && pready && pwrite;
  always_comb
  begin
    nxt_en  = en_ff;
    nxt_d18 = d18_ff;
    if (acc && paddr == {2'b00, IDX_CTL, 2'b00})
      nxt_en = pwdata[CTL_EN];
    if (acc && paddr == {2'b00, IDX_CFG, 2'b00})
      nxt_d18 = pwdata[CFG_18B];
  end
  // Shadow registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_ff  <= 1'b0;
      d18_ff <= 1'b0;
    end
    else
    begin
      en_ff  <= nxt_en;
      d18_ff <= nxt_d18;
    end
  end
  ////////////////////////////////////////
  chk_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_cfg_rsv: assert property (psel && penable && pready && !pwrite &&
    paddr == {2'b00, IDX_CFG, 2'b00} |-> prdata[31:5] == 27'h0)
    else $error("reserved config bits read non-zero");
  chk_head_hold: assert property (vid_valid && !vid_ready |=>
    vid_valid && $stable(vid_rgb) && $stable(vid_de))
    else $error("head word changed while stalled");
  chk_rgb_blank: assert property (vid_valid && !vid_de |->
    vid_rgb == 24'h000000)
    else $error("colour outside data enable");
  chk_gen_off: assert property (
    !en_ff && !vid_valid |=> !vid_valid)
    else $error("pixel while disabled");
  chk_depth_mask: assert property (
    vid_valid && d18_ff |-> (vid_rgb & 24'h030303) == 24'h000000)
    else $error("low colour bits set in 18-bit mode");
  cov_pixel: cover property (vid_valid && vid_ready && vid_de);
  cov_stall: cover property (vid_valid && !vid_ready);
  cov_error: cover property (pslverr);
endmodule : vtpg_chk

bind vtpg_top vtpg_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .vid_valid(vid_valid), .vid_ready(vid_ready), .vid_rgb(vid_rgb),
  .vid_de(vid_de));

// *** bench/tb.sv ***
// Self-checking bench for the video test-pattern generator
module tb
  import vtpg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, stall = 1'b0, fast = 1'b1, arm = 1'b0;
  logic ext_on = 1'b0, ext_pclk = 1'b0, ext_de = 1'b0;
  logic ext_hs = 1'b0, ext_vs = 1'b0;
  logic [11:0] paddr = 12'h000, ecnt = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdv;
  logic pready, pslverr, vid_valid, vid_ready, vid_de, vid_hs, vid_vs, err;
  logic [23:0] vid_rgb, cap0, cap1;
  logic [1:0] n_cap;
  int n_errors = 0, tests_run = 0, cyc = 0, t0;
  logic hs_seen = 1'b0, vs_seen = 1'b0;
  // Control, config and expected first active pixel per case
  localparam logic [7:0] PC [13] = '{8'h11, 8'h31, 8'h41, 8'h51, 8'h11,
    8'h21, 8'hF1, 8'hF3, 8'h31, 8'h31, 8'h31, 8'h25, 8'hE1};
  localparam logic [7:0] PF [13] = '{8'h04, 8'h04, 8'h06, 8'h14, 8'h16,
    8'h04, 8'h04, 8'h04, 8'h00, 8'h08, 8'h0C, 8'h04, 8'h04};
  localparam logic [23:0] PX [13] = '{24'hFFFFFF, 24'hFF0000, 24'hFF00FF,
    24'h0000FC, 24'h000000, 24'h000000, 24'hFFFF00, 24'h0000FF,
    24'hFF0000, 24'hFF0000, 24'hFF0000, 24'hFFFFFF, 24'h808080};

  vtpg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ext_pclk(ext_pclk), .ext_de(ext_de), .ext_hs(ext_hs), .ext_vs(ext_vs),
    .vid_valid(vid_valid), .vid_ready(vid_ready), .vid_rgb(vid_rgb),
    .vid_de(vid_de), .vid_hs(vid_hs), .vid_vs(vid_vs));
  vtpg_sink u_sink (.pclk(pclk), .presetn(presetn), .stall(stall),
    .fast(fast), .arm(arm), .vid_valid(vid_valid), .vid_ready(vid_ready),
    .vid_rgb(vid_rgb), .vid_de(vid_de), .n_cap(n_cap), .cap0(cap0),
    .cap1(cap1));
  ////////////////////////////////////////
  // Clock, watchdog and external raster (pixel clock every 4 cycles)
  always #4 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    // Remember that sync words reached the consumer
    hs_seen <= hs_seen | (vid_valid & vid_ready & vid_hs);
    vs_seen <= vs_seen | (vid_valid & vid_ready & vid_vs);
    ecnt <= ext_on ? ecnt + 12'd1 : 12'd0;
    ext_pclk <= ecnt[1];
    ext_de <= ecnt[5];
    ext_hs <= ecnt[5:2] == 4'h0;
    ext_vs <= ecnt[11:8] == 4'h0;
    if (cyc == 40000)
    begin
      n_errors = n_errors + 1;
      final_report();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run = tests_run + 1;
    if (g !== e)
    begin
      n_errors = n_errors + 1;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // One bus transfer; waits for ready, then releases for a cycle
  task automatic apb(input logic w, input logic [7:0] i,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [7:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0);
    chk(rdv, e);
  endtask : rdc
  task automatic drain();
    @(negedge pclk);
    while (vid_valid !== 1'b0) @(negedge pclk);
    @(posedge pclk);
  endtask : drain
  task automatic grab();
    arm <= 1'b1;
    @(posedge pclk);
    arm <= 1'b0;
    @(negedge pclk);
    while (n_cap !== 2'd2) @(negedge pclk);
    @(posedge pclk);
  endtask : grab
  // Disable, drain, configure, enable, capture two active pixels
  task automatic pat(input logic [7:0] c, input logic [7:0] f);
    apb(1'b1, IDX_CTL, 32'h0);
    drain();
    apb(1'b1, IDX_CFG, {24'h0, f});
    apb(1'b1, IDX_CTL, {24'h0, c});
    grab();
  endtask : pat
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  ////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    ext_on <= 1'b1;
    @(posedge pclk);
    rdc(IDX_CTL, {24'h0, CTL_RST});
    rdc(IDX_CFG, {24'h0, CFG_RST});
    rdc(IDX_FTIME, {24'h0, FTIME_RST});
    rdc(IDX_HTIM, HTIM_RST);
    rdc(IDX_VTIM, VTIM_RST);
    rdc(IDX_PORCH, PORCH_RST);
    apb(1'b1, 8'h63, 32'h1);
    chk({31'h0, err}, 32'h1);
    rdc(8'h63, 32'h0);
    apb(1'b1, IDX_CFG, 32'hFF);
    rdc(IDX_CFG, 32'h1F);
    apb(1'b1, IDX_HTIM, 32'h0010_0008);
    apb(1'b1, IDX_VTIM, 32'h0004_0002);
    apb(1'b1, IDX_PORCH, 32'h0101_0201);
    rdc(IDX_PORCH, 32'h0101_0201);
    $display("test registers done");
    for (int k = 0; k < 13; k++)
    begin
      pat(PC[k], PF[k]);
      chk({8'h0, cap0}, {8'h0, PX[k]});
    end
    pat(8'h61, 8'h04);
    chk({8'h0, cap1 - cap0}, 32'h0001_0101);
    pat(8'h61, 8'h14);
    chk({8'h0, cap1}, 32'h0);
    chk({30'h0, vs_seen, hs_seen}, 32'h3);
    $display("test colours done");
    fast <= 1'b0;
    pat(8'h31, 8'h04);
    repeat (300) @(posedge pclk);
    grab();
    chk({8'h0, cap0}, 32'h00FF_0000);
    fast <= 1'b1;
    apb(1'b1, IDX_FTIME, 32'h2);
    t0 = cyc;
    pat(8'h51, 8'h05);
    chk({8'h0, cap0}, 32'h00FF_FFFF);
    rdv = 32'h0;
    while (rdv[11:8] !== 4'h2) apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, (cyc - t0) inside {[200:400]}}, 32'h1);
    chk({24'h0, rdv[7:0]}, 32'h0);
    grab();
    chk({8'h0, cap0}, 32'h0);
    $display("test scroll done");
    apb(1'b1, IDX_CTL, 32'h0);
    drain();
    stall <= 1'b1;
    apb(1'b1, IDX_CFG, 32'h04);
    apb(1'b1, IDX_CTL, 32'h11);
    repeat (100) @(posedge pclk);
    apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, rdv[12]}, 32'h0);
    chk({31'h0, vid_valid}, 32'h1);
    apb(1'b1, IDX_CFG, 32'h00);
    repeat (200) @(posedge pclk);
    apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, rdv[12]}, 32'h1);
    apb(1'b1, IDX_CTL, 32'h0);
    stall <= 1'b0;
    drain();
    repeat (50) @(posedge pclk);
    chk({31'h0, vid_valid}, 32'h0);
    apb(1'b1, IDX_STAT, 32'h1000);
    apb(1'b0, IDX_STAT, 32'h0);
    chk({31'h0, rdv[12]}, 32'h0);
    $display("test buffer done");
    final_report();
  end
endmodule : tb
